//--- src/spf_flash_dev.sv
// Flash device end: pipelined reads, command interface, sequencer, status.
// Assumes link pins change right after the shared clock edge.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module spf_flash_dev
  import spf_pkg::*;
#(
  parameter int BLK_WORD_W  = 16,
  parameter int PROG_CYCLES = PROG_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  spf_link_if.dev   lnk,
  output logic      o_busy
);
  localparam int IDX_W = BLK_W + BLK_WORD_W;
  localparam int CNT_W = 17;

  if (BLK_WORD_W < 1 || BLK_WORD_W > 16) begin : g_chk_words
    $error("BLK_WORD_W must lie in 1..16");
  end
  if (PROG_CYCLES < 1 || PROG_CYCLES >= 2**CNT_W) begin : g_chk_prog
    $error("PROG_CYCLES out of range");
  end

  typedef struct packed {
    spf_slot_t [1:0]    slot;
    logic [DQ_W-1:0]    dout;
    logic               valid;
    logic               dq_oe_n;
    logic [LAT_W-1:0]   lat;
    spf_mode_t          mode;
    logic               pend;
    logic [7:0]         first;
    logic               we_q;
    spf_seq_t           seq;
    logic [ADDR_W-1:0]  waddr;
    logic [DQ_W-1:0]    wdata;
    logic [1:0]         lanes;
    logic [CNT_W-1:0]   cnt;
    logic [NUM_BLK-1:0] lock;
    logic               prog_err;
    logic               erase_err;
    logic [NUM_BLK-1:0] bfail;
    logic               rb_oe_n;
    logic               busy;
  } spf_dev_st_t;

  spf_dev_st_t       st;
  spf_dev_st_t       next_st;
  logic [DQ_W-1:0]   mem [2**IDX_W];
  logic              en;
  logic              we_rise;
  logic              mem_we;
  logic [IDX_W-1:0]  mem_idx;
  logic [DQ_W-1:0]   mem_wd;
  logic [1:0]        mem_lanes;
  logic [BLK_W-1:0]  wblk;

  function automatic logic [BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:BLK_LSB];
  endfunction : blk_of

  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
    return {blk_of(a), a[BLK_WORD_W:1]};
  endfunction : word_idx

  // Lock bits are nonvolatile, so a power-down keeps them
  function automatic spf_dev_st_t rst_state(input logic [NUM_BLK-1:0] lock);
    spf_dev_st_t s;
    s         = '0;
    s.lat     = LAT_RST;
    s.mode    = MODE_ARRAY;
    s.seq     = SEQ_IDLE;
    s.dq_oe_n = 1'b1;
    s.we_q    = 1'b1;
    s.rb_oe_n = 1'b1;
    s.lock    = lock;
    return s;
  endfunction : rst_state

  // Status words are built on read so ready always tracks the sequencer
  function automatic logic [DQ_W-1:0] src_word(input spf_slot_t s);
    logic [7:0] compat_status_register;
    logic [7:0] global_status_register;
    logic [7:0] block_status_register;
    logic [BLK_W-1:0] b;
    b   = blk_of(s.addr);
    compat_status_register = {st.seq == SEQ_IDLE, 1'b0, st.erase_err, st.prog_err, 4'h0};
    global_status_register = {st.seq == SEQ_IDLE, 1'b0, st.erase_err | st.prog_err, 5'h00};
    block_status_register = {st.seq == SEQ_IDLE, st.lock[b], st.bfail[b], 5'h00};
    case (s.mode)
      MODE_CSR: return {8'h00, compat_status_register};
      MODE_ESR: return {block_status_register, global_status_register};
      default:  return mem[word_idx(s.addr)];
    endcase
  endfunction : src_word

  function automatic logic [DQ_W-1:0] fmt(input spf_slot_t s, input logic [DQ_W-1:0] w);
    if (s.wide) begin
      return w;
    end
    return s.addr[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction : fmt

  assign en      = !lnk.chip_select_0_n && !lnk.chip_select_1_n;
  assign we_rise = en && !st.we_q && lnk.we_n;
  assign wblk    = blk_of(lnk.addr);

  always_comb begin
    next_st   = st;
    mem_we    = 1'b0;
    mem_idx   = word_idx(st.waddr);
    mem_wd    = st.wdata;
    mem_lanes = st.lanes;
    next_st.we_q = lnk.we_n;

    for (int i = 0; i < 2; i++) begin
      if (st.slot[i].busy) begin
        next_st.slot[i].cnt = st.slot[i].cnt - 1'b1;
        if (st.slot[i].cnt == 4'h1) begin
          next_st.slot[i].busy = 1'b0;
          next_st.valid        = 1'b1;
          next_st.dout         = fmt(st.slot[i], src_word(st.slot[i]));
        end
      end
    end
    // Each bank has its own slot so alternating banks overlap their latencies
    if (en && lnk.we_n && st.we_q && !st.pend && !lnk.address_valid_n) begin
      next_st.slot[lnk.addr[1]].busy = 1'b1;
      next_st.slot[lnk.addr[1]].cnt  = st.lat;
      next_st.slot[lnk.addr[1]].addr = lnk.addr;
      next_st.slot[lnk.addr[1]].wide = lnk.width_sel;
      next_st.slot[lnk.addr[1]].mode = st.mode;
    end

    case (st.seq)
      SEQ_PROG: begin
        next_st.cnt = st.cnt - 1'b1;
        if (st.cnt == 17'h00001) begin
          mem_we      = 1'b1;
          next_st.seq = SEQ_IDLE;
        end
      end
      SEQ_ERASE: begin
        mem_we      = 1'b1;
        mem_idx     = {blk_of(st.waddr), st.cnt[BLK_WORD_W-1:0]};
        mem_wd      = '1;
        mem_lanes   = 2'b11;
        next_st.cnt = st.cnt + 1'b1;
        if (&st.cnt[BLK_WORD_W-1:0]) begin
          next_st.seq = SEQ_IDLE;
        end
      end
      SEQ_IDLE: begin
      end
      default: next_st.seq = SEQ_IDLE;
    endcase

    if (we_rise) begin
      if (st.pend) begin
        next_st.pend = 1'b0;
        case (st.first)
          CMD_PROG_A, CMD_PROG_B: begin
            if (st.seq == SEQ_IDLE) begin
              next_st.mode = MODE_CSR;
              if (st.lock[wblk] && !lnk.wp_n) begin
                next_st.prog_err    = 1'b1;
                next_st.bfail[wblk] = 1'b1;
              end else begin
                next_st.seq   = SEQ_PROG;
                next_st.cnt   = CNT_W'(PROG_CYCLES);
                next_st.waddr = lnk.addr;
                next_st.wdata = lnk.width_sel ? lnk.dq : {2{lnk.dq[7:0]}};
                next_st.lanes = lnk.width_sel ? 2'b11 : (lnk.addr[0] ? 2'b10 : 2'b01);
              end
            end
          end
          CMD_ERASE: begin
            if (st.seq == SEQ_IDLE) begin
              next_st.mode = MODE_CSR;
              if (lnk.dq[7:0] != CMD_CONFIRM || (st.lock[wblk] && !lnk.wp_n)) begin
                next_st.erase_err   = 1'b1;
                next_st.bfail[wblk] = 1'b1;
              end else begin
                next_st.seq   = SEQ_ERASE;
                next_st.cnt   = '0;
                next_st.waddr = lnk.addr;
              end
            end
          end
          CMD_LOCK: begin
            if (lnk.dq[7:0] == CMD_CONFIRM) begin
              next_st.lock[wblk] = 1'b1;
            end
          end
          CMD_CFG: begin
            if (lnk.dq[LAT_W-1:0] != '0) begin
              next_st.lat = lnk.dq[LAT_W-1:0];
            end
          end
          default: begin
          end
        endcase
      end else begin
        case (lnk.dq[7:0])
          CMD_READ:   next_st.mode = MODE_ARRAY;
          CMD_RD_CSR: next_st.mode = MODE_CSR;
          CMD_RD_ESR: next_st.mode = MODE_ESR;
          CMD_CLR: begin
            next_st.prog_err  = 1'b0;
            next_st.erase_err = 1'b0;
            next_st.bfail     = '0;
          end
          CMD_PROG_A, CMD_PROG_B, CMD_ERASE, CMD_LOCK, CMD_CFG: begin
            next_st.pend  = 1'b1;
            next_st.first = lnk.dq[7:0];
          end
          default: begin
          end
        endcase
      end
    end

    if (!en || lnk.oe_n) begin
      next_st.valid = 1'b0;
    end
    next_st.dq_oe_n = !(next_st.valid && en && !lnk.oe_n && lnk.we_n);

    if (!lnk.power_down_reset_n) begin
      next_st = rst_state(st.lock);
    end
    if (i_sys_rst) begin
      next_st = rst_state('0);
    end
    next_st.rb_oe_n = next_st.seq == SEQ_IDLE;
    next_st.busy    = next_st.seq != SEQ_IDLE;
  end

  always_ff @(posedge i_clk) begin
    st <= next_st;
  end

  // An aborted operation must not land a last word in the array
  always_ff @(posedge i_clk) begin
    if (mem_we && lnk.power_down_reset_n && !i_sys_rst) begin
      if (mem_lanes[0]) begin
        mem[mem_idx][7:0] <= mem_wd[7:0];
      end
      if (mem_lanes[1]) begin
        mem[mem_idx][15:8] <= mem_wd[15:8];
      end
    end
  end

  assign lnk.dev_dq      = st.dout;
  assign lnk.dev_dq_oe_n = st.dq_oe_n;
  assign lnk.rb_oe_n     = st.rb_oe_n;
  assign o_busy          = st.busy;
endmodule : spf_flash_dev
`default_nettype wire

//--- src/spf_flash_host.sv
// Host end: register port for software, drives link read and write cycles.
// Assumes the device shares the clock; ready/busy is a wired pin.
`timescale 1ns/1ps
`default_nettype none
module spf_flash_host
  import spf_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_irq,
  spf_link_if.host         lnk
);
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   wdata;
    logic [DQ_W-1:0]   rdata;
    logic [LAT_W-1:0]  lat;
    logic              word;
    logic              wp_n;
    logic              pd_n;
    spf_hstate_t       state;
    logic [7:0]        cnt;
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  mask;
    logic [31:0]       bus_rd;
    logic              irq;
    logic              adv_n;
    logic              cs_n;
    logic              oe_n;
    logic              we_n;
    logic              dq_oe_n;
    logic              rb_s1;
    logic              rb_s2;
    logic              rb_q;
  } spf_host_st_t;

  spf_host_st_t st;
  spf_host_st_t next_st;

  always_comb begin
    logic go_rd;
    logic go_wr;
    go_rd   = 1'b0;
    go_wr   = 1'b0;
    next_st = st;
    next_st.bus_rd = '0;
    next_st.rb_s1  = lnk.ready_busy_n;
    next_st.rb_s2  = st.rb_s1;
    next_st.rb_q   = st.rb_s2;

    if (i_wr) begin
      case (i_addr)
        HR_ADDR: next_st.addr  = i_wdata[ADDR_W-1:0];
        HR_DATA: next_st.wdata = i_wdata[DQ_W-1:0];
        HR_CTRL: begin
          go_rd        = i_wdata[CTL_RD];
          go_wr        = i_wdata[CTL_WR];
          next_st.pd_n = !i_wdata[CTL_PD];
          next_st.word = i_wdata[CTL_WORD];
          next_st.lat  = i_wdata[CTL_LAT_LSB +: LAT_W];
          next_st.wp_n = !i_wdata[CTL_WP];
        end
        HR_IRQ:  next_st.irq_st = st.irq_st & ~i_wdata[IRQ_W-1:0];
        HR_MASK: next_st.mask   = i_wdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        HR_ADDR: next_st.bus_rd = {11'h000, st.addr};
        HR_DATA: next_st.bus_rd = {16'h0000, st.rdata};
        HR_CTRL: next_st.bus_rd = {23'h000000, !st.wp_n, st.lat, st.word, !st.pd_n, 2'b00};
        HR_STAT: next_st.bus_rd = {30'h00000000, st.rb_s2, st.state != H_IDLE};
        HR_IRQ:  next_st.bus_rd = {29'h00000000, st.irq_st};
        HR_MASK: next_st.bus_rd = {29'h00000000, st.mask};
        default: next_st.bus_rd = '0;
      endcase
    end

    if (st.rb_s2 && !st.rb_q) begin
      next_st.irq_st[IRQ_RDY] = 1'b1;
    end

    case (st.state)
      H_IDLE: begin
        if (go_rd) begin
          next_st.state = H_ADV;
          next_st.adv_n = 1'b0;
          next_st.cs_n  = 1'b0;
          next_st.oe_n  = 1'b0;
        end else if (go_wr) begin
          next_st.state   = H_WE_LO;
          next_st.cs_n    = 1'b0;
          next_st.we_n    = 1'b0;
          next_st.dq_oe_n = 1'b0;
        end
      end
      H_ADV: begin
        next_st.adv_n = 1'b1;
        next_st.cnt   = {4'h0, st.lat};
        next_st.state = H_WAIT;
      end
      H_WAIT: begin
        if (st.cnt == 8'h00) begin
          next_st.rdata          = st.word ? lnk.dq : {8'h00, lnk.dq[7:0]};
          next_st.cs_n           = 1'b1;
          next_st.oe_n           = 1'b1;
          next_st.irq_st[IRQ_RD] = 1'b1;
          next_st.state          = H_IDLE;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      H_WE_LO: begin
        next_st.we_n  = 1'b1;
        next_st.state = H_WE_HI;
      end
      H_WE_HI: begin
        next_st.cs_n           = 1'b1;
        next_st.dq_oe_n        = 1'b1;
        next_st.irq_st[IRQ_WR] = 1'b1;
        next_st.state          = H_IDLE;
      end
      H_RECOV: begin
        if (st.cnt == 8'h00) begin
          next_st.state = H_IDLE;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      default: next_st.state = H_IDLE;
    endcase

    // Parking in recovery while held down keeps the wait full length
    if (!st.pd_n) begin
      next_st.state   = H_RECOV;
      next_st.cnt     = 8'(PD_RECOV_CYC);
      next_st.adv_n   = 1'b1;
      next_st.cs_n    = 1'b1;
      next_st.oe_n    = 1'b1;
      next_st.we_n    = 1'b1;
      next_st.dq_oe_n = 1'b1;
    end
    next_st.irq = |(next_st.irq_st & next_st.mask);

    if (i_sys_rst) begin
      next_st         = '0;
      next_st.lat     = LAT_RST;
      next_st.word    = 1'b1;
      next_st.wp_n    = 1'b1;
      next_st.pd_n    = 1'b1;
      next_st.state   = H_IDLE;
      next_st.adv_n   = 1'b1;
      next_st.cs_n    = 1'b1;
      next_st.oe_n    = 1'b1;
      next_st.we_n    = 1'b1;
      next_st.dq_oe_n = 1'b1;
      // Synchroniser starts at the pin's idle level so reset raises no false ready edge
      next_st.rb_s1   = 1'b1;
      next_st.rb_s2   = 1'b1;
      next_st.rb_q    = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    st <= next_st;
  end

  assign o_rdata                = st.bus_rd;
  assign o_irq                  = st.irq;
  assign lnk.addr               = st.addr;
  assign lnk.address_valid_n    = st.adv_n;
  assign lnk.chip_select_0_n    = st.cs_n;
  assign lnk.chip_select_1_n    = st.cs_n;
  assign lnk.oe_n               = st.oe_n;
  assign lnk.we_n               = st.we_n;
  assign lnk.width_sel          = st.word;
  assign lnk.wp_n               = st.wp_n;
  assign lnk.power_down_reset_n = st.pd_n;
  assign lnk.host_dq            = st.wdata;
  assign lnk.host_dq_oe_n       = st.dq_oe_n;
endmodule : spf_flash_host
`default_nettype wire

//--- src/spf_link_if.sv
// Pin-level link between the flash device end and its host end.
// Assumes both ends sample on the same clock; resolves shared pins here.
`timescale 1ns/1ps
`default_nettype none
interface spf_link_if;
  import spf_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              address_valid_n;
  logic              chip_select_0_n;
  logic              chip_select_1_n;
  logic              oe_n;
  logic              we_n;
  logic              width_sel;
  logic              wp_n;
  logic              power_down_reset_n;
  logic [DQ_W-1:0]   host_dq;
  logic              host_dq_oe_n;
  logic [DQ_W-1:0]   dev_dq;
  logic              dev_dq_oe_n;
  logic [DQ_W-1:0]   dq;
  logic              rb_oe_n;
  logic              ready_busy_n;

  // Undriven bus floats to ones, as a weak pull-up would leave it
  assign dq = !dev_dq_oe_n ? dev_dq : (!host_dq_oe_n ? host_dq : '1);
  // Open-drain: only pulled low, otherwise the pull-up wins
  assign ready_busy_n = rb_oe_n;

  modport dev (input addr, address_valid_n, chip_select_0_n, chip_select_1_n, oe_n,
               we_n, width_sel, wp_n, power_down_reset_n, dq,
               output dev_dq, dev_dq_oe_n, rb_oe_n);
  modport host (output addr, address_valid_n, chip_select_0_n, chip_select_1_n, oe_n,
                we_n, width_sel, wp_n, power_down_reset_n, host_dq, host_dq_oe_n,
                input dq, ready_busy_n);
endinterface : spf_link_if
`default_nettype wire

//--- src/spf_pkg.sv
// Constants and types shared by both ends of the synchronous flash link.
// Assumes both ends run on one 200 MHz clock (5 ns period).
// Functional notes
// - Read address taken on clock edge with strobe low
// - Clock and strobe ignored during write sequences
// - Data driven after programmed latency count elapses
// - Data held until deselect or next access completes
// - Read latency setting resets to four
// - Zero-wait reads need alternating even/odd banks
// - Chip enabled only while both selects low
// - Width select picks byte or word operation
// - Power-down aborts sequencer, clears error status but keeps lock bits
// - Host waits 300 ns after power-down release
// - Program and erase start by two writes
// - Locked blocks refuse changes while write-protected
// - Erase touches only the addressed block
// - Compatible, global and per-block status reported
// - Ready/busy output is open-drain
// - Power-down exit returns to read-array mode
// - Address and data latched on write strobe rise
package spf_pkg;
  localparam int ADDR_W  = 21;
  localparam int DQ_W    = 16;
  localparam int NUM_BLK = 16;
  localparam int BLK_W   = 4;
  localparam int BLK_LSB = 17;
  localparam int LAT_W   = 4;
  localparam logic [LAT_W-1:0] LAT_RST = 4'h4;

  localparam int CLK_PS       = 5000;
  localparam int PD_RECOV_NS  = 300;
  localparam int PD_RECOV_CYC = (PD_RECOV_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int PROG_NS      = 6000;
  localparam int PROG_CYC     = (PROG_NS * 1000 + CLK_PS - 1) / CLK_PS;

  localparam logic [7:0] CMD_READ    = 8'hff;
  localparam logic [7:0] CMD_RD_CSR  = 8'h70;
  localparam logic [7:0] CMD_RD_ESR  = 8'h71;
  localparam logic [7:0] CMD_CLR     = 8'h50;
  localparam logic [7:0] CMD_PROG_A  = 8'h40;
  localparam logic [7:0] CMD_PROG_B  = 8'h10;
  localparam logic [7:0] CMD_ERASE   = 8'h20;
  localparam logic [7:0] CMD_LOCK    = 8'h77;
  localparam logic [7:0] CMD_CFG     = 8'h60;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;

  localparam int ST_READY = 7;
  localparam int ST_LOCK  = 6;
  localparam int ST_ERASE = 5;
  localparam int ST_PROG  = 4;

  localparam logic [7:0] HR_ADDR = 8'h00;
  localparam logic [7:0] HR_DATA = 8'h04;
  localparam logic [7:0] HR_CTRL = 8'h08;
  localparam logic [7:0] HR_STAT = 8'h0c;
  localparam logic [7:0] HR_IRQ  = 8'h10;
  localparam logic [7:0] HR_MASK = 8'h14;
  localparam int CTL_RD      = 0;
  localparam int CTL_WR      = 1;
  localparam int CTL_PD      = 2;
  localparam int CTL_WORD    = 3;
  localparam int CTL_LAT_LSB = 4;
  localparam int CTL_WP      = 8;
  localparam int IRQ_RD      = 0;
  localparam int IRQ_WR      = 1;
  localparam int IRQ_RDY     = 2;
  localparam int IRQ_W       = 3;

  typedef enum logic [2:0] {
    MODE_ARRAY = 3'b001, MODE_CSR = 3'b010, MODE_ESR = 3'b100
  } spf_mode_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001, SEQ_PROG = 3'b010, SEQ_ERASE = 3'b100
  } spf_seq_t;

  typedef enum logic [5:0] {
    H_IDLE = 6'b000001, H_ADV = 6'b000010, H_WAIT = 6'b000100,
    H_WE_LO = 6'b001000, H_WE_HI = 6'b010000, H_RECOV = 6'b100000
  } spf_hstate_t;

  typedef struct packed {
    logic              busy;
    logic [LAT_W-1:0]  cnt;
    logic [ADDR_W-1:0] addr;
    logic              wide;
    spf_mode_t         mode;
  } spf_slot_t;
endpackage : spf_pkg

//--- verification/spf_link_assertions.sv
// Pin-level checks on the link between the host and device ends.
// Assumes one shared clock and a synchronous, active-high reset.
`timescale 1ns/1ps
`default_nettype none
module spf_link_checker
  import spf_pkg::*;
(
  input wire logic            i_clk,
  input wire logic            i_sys_rst,
  input wire logic            address_valid_n,
  input wire logic            chip_select_0_n,
  input wire logic            chip_select_1_n,
  input wire logic            oe_n,
  input wire logic            we_n,
  input wire logic            width_sel,
  input wire logic            power_down_reset_n,
  input wire logic [DQ_W-1:0] dev_dq,
  input wire logic            dev_dq_oe_n,
  input wire logic            rb_oe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [5:0] up_cnt;
  // Saturates so a long idle stretch never wraps back below the limit
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) up_cnt <= 6'h3f;
    else if (!power_down_reset_n) up_cnt <= 6'h00;
    else if (up_cnt != 6'h3f) up_cnt <= up_cnt + 6'h01;
  end
  a_drive_when_sel: assert property (!dev_dq_oe_n |-> !$past(chip_select_0_n) &&
    !$past(chip_select_1_n) && !$past(oe_n) && $past(we_n)) else $error("dq driven unselected");
  a_pd_quiet: assert property (!power_down_reset_n |=> dev_dq_oe_n && rb_oe_n)
    else $error("outputs active in power-down");
  a_read_latency: assert property (!address_valid_n && !chip_select_0_n &&
    !chip_select_1_n && we_n |=> dev_dq_oe_n[*3] ##[1:2] !dev_dq_oe_n)
    else $error("read data not on time");
  a_busy_start: assert property ($fell(rb_oe_n) |-> ($past(we_n) && !$past(we_n, 2)) ||
    ($past(we_n, 2) && !$past(we_n, 3))) else $error("busy without write strobe rise");
  a_byte_upper: assert property (!dev_dq_oe_n && !width_sel |-> dev_dq[15:8] == 8'h00)
    else $error("upper byte driven in byte mode");
  a_data_hold: assert property (!dev_dq_oe_n && !$past(dev_dq_oe_n) |-> $stable(dev_dq))
    else $error("read data changed while held");
  a_pd_recovery: assert property (!address_valid_n |-> up_cnt >= 6'h3c)
    else $error("address latched too soon after power-down");
  a_write_sel: assert property (!we_n |-> !chip_select_0_n && !chip_select_1_n &&
    address_valid_n) else $error("write strobe without select");
  c_read: cover property (!address_valid_n);
  c_busy: cover property ($fell(rb_oe_n));
  c_pd: cover property ($rose(power_down_reset_n));
  c_byte: cover property (!dev_dq_oe_n && !width_sel);
endmodule : spf_link_checker
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench: host and device ends joined by the link interface.
// Assumes the host register map and timing described with the design.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spf_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic        o_irq;
  logic        o_busy;
  logic [31:0] d;
  int          failures = 0;
  int          checked = 0;
  spf_link_if lnk ();
  spf_flash_dev #(.BLK_WORD_W(4), .PROG_CYCLES(8)) i_spf_flash_dev (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .lnk(lnk.dev), .o_busy(o_busy));
  spf_flash_host i_spf_flash_host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .lnk(lnk.host));
  spf_link_checker i_spf_link_checker (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .address_valid_n(lnk.address_valid_n), .chip_select_0_n(lnk.chip_select_0_n),
    .chip_select_1_n(lnk.chip_select_1_n), .oe_n(lnk.oe_n), .we_n(lnk.we_n),
    .width_sel(lnk.width_sel), .power_down_reset_n(lnk.power_down_reset_n),
    .dev_dq(lnk.dev_dq), .dev_dq_oe_n(lnk.dev_dq_oe_n), .rb_oe_n(lnk.rb_oe_n));
  always #2.5 i_clk = ~i_clk;
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  // Bounded wait on one status bit
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    rd(HR_STAT);
    while (d[b] !== v && n < 400) begin
      rd(HR_STAT);
      n++;
    end
    check("stat_poll", {31'h0, d[b]}, {31'h0, v});
  endtask : poll
  task automatic lw(input logic [31:0] v, input logic [31:0] w);
    wr(HR_DATA, v);
    wr(HR_CTRL, 32'h4a | w);
    poll(0, 1'b0);
  endtask : lw
  task automatic lr(input logic [31:0] a, input logic [31:0] c);
    wr(HR_ADDR, a);
    wr(HR_CTRL, c);
    poll(0, 1'b0);
    rd(HR_DATA);
  endtask : lr
  // Ready/busy is synchronised in the host, so give it a few cycles to show busy
  task automatic cmd2(input logic [31:0] a, input logic [31:0] c1, input logic [31:0] c2,
                      input logic [31:0] w, input logic b);
    wr(HR_ADDR, a);
    lw(c1, w);
    lw(c2, w);
    check("busy_flag", {31'h0, o_busy}, {31'h0, b});
    repeat (6) @(posedge i_clk);
    poll(1, 1'b1);
  endtask : cmd2
  task automatic t_prog;
    rd(HR_IRQ);
    check("irq_reset", d, 32'h0);
    cmd2(32'h0, 32'h40, 32'h1234, 32'h0, 1'b1);
    lw(32'hff, 32'h0);
    lr(32'h0, 32'h49);
    check("word_read", d, 32'h1234);
    lr(32'h1, 32'h41);
    check("byte_high", d, 32'h12);
    lr(32'h0, 32'h41);
    check("byte_low", d, 32'h34);
    rd(HR_IRQ);
    check("irq_status", d, 32'h7);
    $display("test prog done");
  endtask : t_prog
  task automatic t_erase;
    cmd2(32'h20000, 32'h40, 32'h5678, 32'h0, 1'b1);
    cmd2(32'h20000, 32'h20, 32'hd0, 32'h0, 1'b1);
    lw(32'hff, 32'h0);
    lr(32'h20000, 32'h49);
    check("erased", d, 32'hffff);
    lr(32'h0, 32'h49);
    check("other_block", d, 32'h1234);
    $display("test erase done");
  endtask : t_erase
  task automatic t_lock;
    cmd2(32'h40000, 32'h40, 32'haaaa, 32'h0, 1'b1);
    cmd2(32'h40000, 32'h77, 32'hd0, 32'h0, 1'b0);
    cmd2(32'h40000, 32'h40, 32'h5555, 32'h100, 1'b0);
    lr(32'h40000, 32'h141);
    check("refused_flag", {30'h0, d[7], d[4]}, 32'h3);
    wr(HR_CTRL, 32'h4c);
    repeat (4) @(posedge i_clk);
    wr(HR_CTRL, 32'h48);
    repeat (70) @(posedge i_clk);
    lr(32'h40000, 32'h49);
    check("array_after_pd", d, 32'haaaa);
    lw(32'h70, 32'h0);
    lr(32'h40000, 32'h41);
    check("status_cleared", {31'h0, d[4]}, 32'h0);
    $display("test lock done");
  endtask : t_lock
  task automatic t_irq;
    wr(HR_IRQ, 32'h7);
    wr(HR_MASK, 32'h1);
    lr(32'h0, 32'h49);
    check("irq_on", {31'h0, o_irq}, 32'h1);
    wr(HR_MASK, 32'h0);
    rd(HR_MASK);
    check("irq_masked", {31'h0, o_irq}, 32'h0);
    wr(HR_IRQ, 32'h7);
    rd(HR_IRQ);
    check("irq_cleared", d, 32'h0);
    rd(8'h40);
    check("unmapped", d, 32'h0);
    check("dev_idle", {31'h0, o_busy}, 32'h0);
    $display("test irq done");
  endtask : t_irq
  // Host latency 3 captures one edge early, so a device still at 4 reads as all ones
  task automatic t_cfg;
    lw(32'hff, 32'h0);
    lw(32'h60, 32'h0);
    lw(32'h3, 32'h0);
    lr(32'h0, 32'h39);
    check("latency_3", d, 32'h1234);
    lw(32'h71, 32'h0);
    lr(32'h40000, 32'h39);
    check("ext_status", d, 32'hc080);
    cmd2(32'h0, 32'h20, 32'h0, 32'h0, 1'b0);
    lr(32'h0, 32'h39);
    check("erase_refused", d, 32'ha0);
    lw(32'h50, 32'h0);
    lr(32'h0, 32'h39);
    check("errors_cleared", d, 32'h80);
    $display("test cfg done");
  endtask : t_cfg
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_prog();
    t_erase();
    t_lock();
    t_irq();
    t_cfg();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
